//--- core/pmc_cfg_pkg.sv
package pmc_cfg_pkg;

  // Register offsets
  localparam logic [6:0] OFS_LTS_CFG = 7'h06;
  localparam logic [6:0] OFS_USB_CFG = 7'h13;
  localparam logic [6:0] OFS_PROT_LAST = 7'h18;
  localparam logic [6:0] OFS_RESTART_WORD = 7'h1A;
  localparam logic [6:0] OFS_UNLOCK_KEY = 7'h1B;
  localparam logic [6:0] OFS_STATUS = 7'h1F;
  localparam logic [6:0] OFS_NVM_BASE = 7'h40;
  localparam logic [6:0] OFS_NVM_RO_BASE = 7'h76;

  // Protected bank size
  localparam int BANK_DEPTH = 25;

  // Field positions
  localparam int BIT_NO_PROTECT = 0;
  localparam int BIT_FRC_BAT_HIZ = 2;
  localparam int BIT_FRC_HRV_HIZ = 3;
  localparam int CHG_SEL_LSB = 0;
  localparam int CHG_SEL_W = 2;

  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] WORD_RESET = 8'h00;
  localparam logic [7:0] KEY_RESET = 8'h00;

  // Key and restart codes
  localparam logic [7:0] KEY_RESTART = 8'hE2;
  localparam logic [7:0] KEY_CFG = 8'h4B;
  localparam logic [7:0] KEY_NVM = 8'hA5;
  localparam logic [7:0] RESTART_CODE = 8'hAB;

  // Storage check delay after boot
  localparam int CLK_PERIOD_NS = 10;
  localparam int LTS_CHECK_NS = 10000;
  localparam int LTS_CHECK_CYC = (LTS_CHECK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 10;

endpackage

//--- core/pmc_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module pmc_sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level in and out
  input wire logic d,
  output logic q
);

  logic meta_q;

  // Two-stage capture of an outside level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule
`default_nettype wire

//--- core/pmc_protected_cfg.sv
`timescale 1ns/10ps
`default_nettype none
module pmc_protected_cfg (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Register port from serial front end
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [6:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic TXN_END,
  output logic [7:0] REG_RDATA,
  // Analog status pins
  input wire logic USB_DET,
  input wire logic LTS_BELOW_MIN,
  // Indicator levels from supervisor
  input wire logic HRV_LOW_LVL,
  input wire logic BAT_LOW_LVL,
  // Indicator pins
  output logic HRV_LOW_O,
  output logic HRV_LOW_OE,
  output logic BAT_LOW_O,
  output logic BAT_LOW_OE,
  // USB charging
  output logic USB_REG_EN,
  output logic [1:0] CHG_SEL,
  // Storage connection and restart
  output logic LTS_CONNECT,
  output logic COLD_START,
  output logic SOFT_RST,
  // Nonvolatile memory write strobe
  output logic NVM_WR,
  output logic [5:0] NVM_ADDR,
  output logic [7:0] NVM_WDATA
);

  typedef enum logic [1:0] {ST_BOOT, ST_LTS, ST_COLD} boot_e;

  logic usb_s;
  logic lts_low_s;
  logic [7:0] bank_q [0:pmc_cfg_pkg::BANK_DEPTH-1];
  logic [7:0] key_q, key_d;
  logic [7:0] word_q, word_d;
  logic [pmc_cfg_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic prot_latch_q, prot_latch_d;
  logic soft_q;
  boot_e state_q, state_d;
  logic cold_d, conn_d;
  logic [7:0] rdata_d;

  // Outside levels
  pmc_sync2 u_sync_usb (
    .clk(MCLK),
    .rst_n(RST_N),
    .d(USB_DET),
    .q(usb_s)
  );
  pmc_sync2 u_sync_lts (
    .clk(MCLK),
    .rst_n(RST_N),
    .d(LTS_BELOW_MIN),
    .q(lts_low_s)
  );

  // Address decode
  wire in_bank = (REG_ADDR <= pmc_cfg_pkg::OFS_PROT_LAST);
  wire wr_key = REG_WR && (REG_ADDR == pmc_cfg_pkg::OFS_UNLOCK_KEY);
  wire wr_word = REG_WR && (REG_ADDR == pmc_cfg_pkg::OFS_RESTART_WORD);
  wire in_nvm = (REG_ADDR >= pmc_cfg_pkg::OFS_NVM_BASE) && (REG_ADDR < pmc_cfg_pkg::OFS_NVM_RO_BASE);
  wire bank_we = REG_WR && in_bank && (key_q == pmc_cfg_pkg::KEY_CFG);
  wire nvm_we = REG_WR && in_nvm && (key_q == pmc_cfg_pkg::KEY_NVM);
  wire restart = wr_word && (key_q == pmc_cfg_pkg::KEY_RESTART) && (REG_WDATA == pmc_cfg_pkg::RESTART_CODE);
  wire [4:0] bank_idx = REG_ADDR[4:0];

  // Configuration fields in use
  wire [7:0] usb_cfg = bank_q[pmc_cfg_pkg::OFS_USB_CFG[4:0]];
  wire no_protect = bank_q[pmc_cfg_pkg::OFS_LTS_CFG[4:0]][pmc_cfg_pkg::BIT_NO_PROTECT];
  wire [1:0] sel = usb_cfg[pmc_cfg_pkg::CHG_SEL_LSB +: pmc_cfg_pkg::CHG_SEL_W];
  wire frc_hrv = usb_cfg[pmc_cfg_pkg::BIT_FRC_HRV_HIZ];
  wire frc_bat = usb_cfg[pmc_cfg_pkg::BIT_FRC_BAT_HIZ];
  wire cnt_done = (cnt_q == pmc_cfg_pkg::CNT_W'(pmc_cfg_pkg::LTS_CHECK_CYC - 1));

  // Key: cleared by transaction end and soft restart
  always_comb begin
    key_d = key_q;
    if (wr_key) begin
      key_d = REG_WDATA;
    end
    if (TXN_END) begin
      key_d = pmc_cfg_pkg::KEY_RESET;
    end
    if (soft_q) begin
      key_d = pmc_cfg_pkg::KEY_RESET;
    end
  end

  // Restart word held only under its key
  always_comb begin
    word_d = word_q;
    if (wr_word) begin
      word_d = REG_WDATA;
    end
    if (key_d != pmc_cfg_pkg::KEY_RESTART) begin
      word_d = pmc_cfg_pkg::WORD_RESET;
    end
  end

  // Key, word and restart pulse
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      key_q <= pmc_cfg_pkg::KEY_RESET;
      word_q <= pmc_cfg_pkg::WORD_RESET;
      soft_q <= 1'b0;
    end else begin
      key_q <= key_d;
      word_q <= word_d;
      soft_q <= restart;
    end
  end

  // Protected bank, reloaded on restart
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < pmc_cfg_pkg::BANK_DEPTH; i++) begin
        bank_q[i] <= pmc_cfg_pkg::CFG_RESET;
      end
    end else if (soft_q) begin
      for (int i = 0; i < pmc_cfg_pkg::BANK_DEPTH; i++) begin
        bank_q[i] <= pmc_cfg_pkg::CFG_RESET;
      end
    end else if (bank_we) begin
      bank_q[bank_idx] <= REG_WDATA;
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    if (in_bank) begin
      rdata_d = bank_q[bank_idx];
    end
    if (REG_ADDR == pmc_cfg_pkg::OFS_LTS_CFG) begin
      rdata_d = {7'h00, no_protect};
    end
    if (REG_ADDR == pmc_cfg_pkg::OFS_RESTART_WORD) begin
      rdata_d = word_q;
    end
    if (REG_ADDR == pmc_cfg_pkg::OFS_UNLOCK_KEY) begin
      rdata_d = key_q;
    end
    if (REG_ADDR == pmc_cfg_pkg::OFS_STATUS) begin
      rdata_d = {3'h0, usb_s, lts_low_s, prot_latch_q, state_q};
    end
  end

  // Storage start attempt sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    prot_latch_d = prot_latch_q;
    cold_d = 1'b0;
    case (state_q)
      ST_BOOT: begin
        cnt_d = cnt_q + 1'b1;
        if (prot_latch_q) begin
          state_d = ST_COLD;
        end else if (cnt_done) begin
          cnt_d = '0;
          if (lts_low_s && !no_protect) begin
            prot_latch_d = 1'b1;
            cold_d = 1'b1;
            state_d = ST_COLD;
          end else begin
            state_d = ST_LTS;
          end
        end
      end
      ST_LTS: begin
        if (lts_low_s && !no_protect) begin
          prot_latch_d = 1'b1;
          cold_d = 1'b1;
          state_d = ST_COLD;
        end
      end
      ST_COLD: begin
        state_d = ST_COLD;
      end
      default: begin
        state_d = ST_BOOT;
      end
    endcase
    if (soft_q) begin
      state_d = ST_BOOT;
      cnt_d = '0;
    end
  end

  assign conn_d = (state_d == ST_BOOT && !prot_latch_d) || (state_d == ST_LTS);

  // Sequencer registers; latch survives soft restart
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_BOOT;
      cnt_q <= '0;
      prot_latch_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      prot_latch_q <= prot_latch_d;
    end
  end

  // Registered outputs
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
      HRV_LOW_O <= 1'b0;
      HRV_LOW_OE <= 1'b0;
      BAT_LOW_O <= 1'b0;
      BAT_LOW_OE <= 1'b0;
      USB_REG_EN <= 1'b0;
      CHG_SEL <= 2'h0;
      LTS_CONNECT <= 1'b0;
      COLD_START <= 1'b0;
      SOFT_RST <= 1'b0;
      NVM_WR <= 1'b0;
      NVM_ADDR <= 6'h00;
      NVM_WDATA <= 8'h00;
    end else begin
      if (REG_RD) begin
        REG_RDATA <= rdata_d;
      end
      HRV_LOW_O <= HRV_LOW_LVL;
      HRV_LOW_OE <= !(frc_hrv && usb_s);
      BAT_LOW_O <= BAT_LOW_LVL;
      BAT_LOW_OE <= !(frc_bat && usb_s);
      USB_REG_EN <= usb_s;
      CHG_SEL <= usb_s ? sel : 2'h0;
      LTS_CONNECT <= conn_d;
      COLD_START <= cold_d;
      SOFT_RST <= restart;
      NVM_WR <= nvm_we;
      NVM_ADDR <= REG_ADDR[5:0];
      NVM_WDATA <= REG_WDATA;
    end
  end

  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  sequence s_restart_req;
    REG_WR && REG_ADDR == pmc_cfg_pkg::OFS_RESTART_WORD && REG_WDATA == pmc_cfg_pkg::RESTART_CODE
      && key_q == pmc_cfg_pkg::KEY_RESTART && !TXN_END;
  endsequence
  sequence s_restart_done;
    SOFT_RST ##1 (key_q == pmc_cfg_pkg::KEY_RESET && word_q == pmc_cfg_pkg::WORD_RESET);
  endsequence

  AST_CHG_SEL: assert property (##1 CHG_SEL == ($past(usb_s) ? $past(sel) : 2'h0))
    else $error("charge select mismatch");
  AST_HRV_HIZ: assert property (frc_hrv && usb_s |=> !HRV_LOW_OE)
    else $error("harvester pin not floated");
  AST_BAT_HIZ: assert property (!(frc_bat && usb_s) |=> BAT_LOW_OE)
    else $error("storage pin floated wrongly");
  AST_RESTART: assert property (s_restart_req |=> s_restart_done)
    else $error("restart sequence wrong");
  AST_WORD_FORCED: assert property (key_q != pmc_cfg_pkg::KEY_RESTART |-> word_q == 8'h00)
    else $error("restart word held without key");
  AST_BANK_LOCK: assert property (REG_WR && in_bank && key_q != pmc_cfg_pkg::KEY_CFG && !soft_q
    |=> bank_q[$past(bank_idx)] == $past(bank_q[bank_idx]))
    else $error("protected write accepted");
  AST_READ_KEY: assert property (REG_RD && REG_ADDR == pmc_cfg_pkg::OFS_UNLOCK_KEY
    |=> REG_RDATA == $past(key_q))
    else $error("key readback wrong");
  AST_KEY_CLR: assert property (TXN_END |=> key_q == 8'h00)
    else $error("key survived transaction end");
  AST_NVM_KEY: assert property (NVM_WR |-> $past(key_q) == pmc_cfg_pkg::KEY_NVM)
    else $error("nvm write without key");
  AST_NO_PROTECT: assert property (state_q == ST_LTS && no_protect |=> state_q == ST_LTS || $past(soft_q))
    else $error("storage dropped while disabled");
  AST_ONE_TRY: assert property ($rose(prot_latch_q) |-> COLD_START ##1 !LTS_CONNECT[*3])
    else $error("storage retried after protection");
  AST_USB_REG: assert property (usb_s |=> USB_REG_EN)
    else $error("regulator not enabled");
  AST_OTHER_KEY: assert property (key_q != pmc_cfg_pkg::KEY_CFG && key_q != pmc_cfg_pkg::KEY_NVM
    && key_q != pmc_cfg_pkg::KEY_RESTART |-> !bank_we ##1 (!NVM_WR && !SOFT_RST))
    else $error("unknown key unlocked access");

endmodule
`default_nettype wire

//--- testbench/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // Clock
  input wire logic MCLK,
  // Register port
  output logic REG_WR,
  output logic REG_RD,
  output logic [6:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  output logic TXN_END,
  input wire logic [7:0] REG_RDATA
);
  // Idle port
  initial begin
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 7'h00;
    REG_WDATA = 8'h00;
    TXN_END = 1'b0;
  end

  // Write held over its taking edge; caller closes it
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge MCLK);
    REG_RD = 1'b0;
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
  endtask

  // Read; data taken one cycle after request
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge MCLK);
    REG_WR = 1'b0;
    REG_RD = 1'b1;
    REG_ADDR = a;
    @(negedge MCLK);
    REG_RD = 1'b0;
    d = REG_RDATA;
    REG_ADDR = ~a;
  endtask

  // Transaction close; key and data sent before it
  // key inside transaction
  task automatic txn_end();
    @(negedge MCLK);
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_WDATA = ~REG_WDATA;
    TXN_END = 1'b1;
    @(negedge MCLK);
    TXN_END = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic MCLK, RST_N, REG_WR, REG_RD, TXN_END, USB_DET, LTS_BELOW_MIN, HRV_LOW_LVL, BAT_LOW_LVL;
  logic [6:0] REG_ADDR;
  logic [7:0] REG_WDATA, REG_RDATA, NVM_WDATA, nvm_d, rd_v;
  logic HRV_LOW_O, HRV_LOW_OE, BAT_LOW_O, BAT_LOW_OE, USB_REG_EN, LTS_CONNECT, COLD_START, SOFT_RST, NVM_WR;
  logic [1:0] CHG_SEL, s;
  logic [5:0] NVM_ADDR, nvm_a;
  int fail_count = 0;
  int check_count = 0;
  int n_rst = 0;
  int n_nvm = 0;
  int n_cold = 0;

  pmc_protected_cfg pmc_protected_cfg_inst (.MCLK(MCLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .TXN_END(TXN_END), .REG_RDATA(REG_RDATA), .USB_DET(USB_DET),
    .LTS_BELOW_MIN(LTS_BELOW_MIN), .HRV_LOW_LVL(HRV_LOW_LVL), .BAT_LOW_LVL(BAT_LOW_LVL), .HRV_LOW_O(HRV_LOW_O),
    .HRV_LOW_OE(HRV_LOW_OE), .BAT_LOW_O(BAT_LOW_O), .BAT_LOW_OE(BAT_LOW_OE), .USB_REG_EN(USB_REG_EN),
    .CHG_SEL(CHG_SEL), .LTS_CONNECT(LTS_CONNECT), .COLD_START(COLD_START), .SOFT_RST(SOFT_RST),
    .NVM_WR(NVM_WR), .NVM_ADDR(NVM_ADDR), .NVM_WDATA(NVM_WDATA));
  host_model host_model_inst (.MCLK(MCLK), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .TXN_END(TXN_END), .REG_RDATA(REG_RDATA));

  // Clock
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  // Pulse counters, sampled mid-cycle where outputs are settled
  always @(negedge MCLK) begin
    if (SOFT_RST === 1'b1) n_rst++;
    if (COLD_START === 1'b1) n_cold++;
    if (NVM_WR === 1'b1) begin
      n_nvm++;
      nvm_a = NVM_ADDR;
      nvm_d = NVM_WDATA;
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_model_inst.wr(a, d);
  endtask

  task automatic tend();
    host_model_inst.txn_end();
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    host_model_inst.rd(a, rd_v);
    chk(rd_v, exp);
  endtask

  task automatic waitc(input int n);
    repeat (n) @(negedge MCLK);
  endtask

  task automatic restart();
    wr(7'h1B, 8'hE2);
    wr(7'h1A, 8'hAB);
    tend();
  endtask

  task automatic finish_test();
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end

  // Main sequence
  initial begin
    RST_N = 1'b0;
    USB_DET = 1'b1;
    LTS_BELOW_MIN = 1'b0;
    HRV_LOW_LVL = 1'b1;
    BAT_LOW_LVL = 1'b0;
    waitc(3);
    RST_N = 1'b1;
    waitc(4);
    chk({7'h0, LTS_CONNECT}, 8'h01);
    chk({4'h0, HRV_LOW_O, BAT_LOW_O, HRV_LOW_OE, BAT_LOW_OE}, 8'h0B);
    wr(7'h13, 8'h0F);
    tend();
    rchk(7'h13, 8'h00);
    wr(7'h1B, 8'h4A);
    wr(7'h13, 8'h0F);
    tend();
    rchk(7'h13, 8'h00);
    for (int i = 0; i < 4; i++) begin
      s = i[1:0];
      wr(7'h1B, 8'h4B);
      wr(7'h13, {4'h0, s, s});
      tend();
      waitc(2);
      chk({6'h0, CHG_SEL}, {6'h0, s});
      chk({6'h0, HRV_LOW_OE, BAT_LOW_OE}, {6'h0, ~s});
      rchk(7'h13, {4'h0, s, s});
    end
    USB_DET = 1'b0;
    waitc(5);
    chk({4'h0, USB_REG_EN, CHG_SEL, HRV_LOW_OE}, 8'h01);
    USB_DET = 1'b1;
    waitc(5);
    chk({4'h0, USB_REG_EN, CHG_SEL, BAT_LOW_OE}, 8'h0E);
    wr(7'h1B, 8'h4B);
    tend();
    wr(7'h13, 8'h00);
    tend();
    rchk(7'h13, 8'h0F);
    wr(7'h1B, 8'hA5);
    wr(7'h45, 8'h3C);
    tend();
    chk({2'h0, nvm_a}, 8'h05);
    chk(nvm_d, 8'h3C);
    wr(7'h1B, 8'h4B);
    wr(7'h46, 8'h11);
    wr(7'h1B, 8'hA5);
    wr(7'h76, 8'h22);
    tend();
    chk(8'(n_nvm), 8'h01);
    wr(7'h1A, 8'hAB);
    tend();
    rchk(7'h1A, 8'h00);
    wr(7'h1B, 8'hE2);
    wr(7'h1A, 8'h55);
    rchk(7'h1A, 8'h55);
    chk(8'(n_rst), 8'h00);
    restart();
    waitc(2);
    chk(8'(n_rst), 8'h01);
    rchk(7'h1B, 8'h00);
    rchk(7'h13, 8'h00);
    wr(7'h1A, 8'hAB);
    tend();
    chk(8'(n_rst), 8'h01);
    LTS_BELOW_MIN = 1'b1;
    wr(7'h1B, 8'h4B);
    wr(7'h13, 8'h00);
    wr(7'h06, 8'h01);
    tend();
    waitc(1100);
    chk({7'h0, LTS_CONNECT}, 8'h01);
    wr(7'h1B, 8'h4B);
    wr(7'h06, 8'h00);
    tend();
    waitc(5);
    chk({6'h0, LTS_CONNECT, COLD_START}, 8'h00);
    chk(8'(n_cold), 8'h01);
    LTS_BELOW_MIN = 1'b0;
    restart();
    waitc(1100);
    chk({7'h0, LTS_CONNECT}, 8'h00);
    @(negedge MCLK);
    RST_N = 1'b0;
    LTS_BELOW_MIN = 1'b1;
    waitc(3);
    RST_N = 1'b1;
    waitc(900);
    chk({7'h0, LTS_CONNECT}, 8'h01);
    waitc(200);
    chk({7'h0, LTS_CONNECT}, 8'h00);
    chk(8'(n_cold), 8'h02);
    // Status: USB, storage low, latch set, cold state
    rchk(7'h1F, 8'h1E);
    finish_test();
  end
endmodule
`default_nettype wire
